// File: design/timer_counter16.sv
// Sixteen-bit timer/counter with prescaler, trigger clear and APB registers
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps

// Overview of operation
// RULE1 - Counter mode counts rising edges of oscillator pin, else external pin.
// RULE2 - Sync mode passes the prescaled count through a sync stage.
// RULE3 - Prescaler counts selected input ticks ahead of the sync stage.
// RULE4 - Sync counter mode holds the count in sleep; prescaler keeps going.
// RULE5 - Async mode counts during sleep and its overflow can wake the CPU.
// RULE6 - Async counter mode is not a valid capture/compare time base.
// RULE7 - Byte reads of a running counter are not latched; the two bytes can disagree.
// RULE8 - Software should stop the counter before writing the count bytes.
// RULE9 - Oscillator enable bit turns the crystal oscillator on, also in sleep.
// RULE10 - Software waits its own start-up delay after enabling the oscillator.
// RULE11 - Compare match in trigger mode clears the sixteen-bit count.
// RULE12 - A trigger clear never sets the overflow flag.
// RULE13 - Trigger clear works in timer or sync counter mode only.
// RULE14 - A count write in the trigger cycle wins over the clear.
// RULE15 - Under trigger clear the compare value acts as the count period.
// RULE16 - No reset clears the count bytes; only the trigger does.
// RULE17 - Control clears on power-on or brown-out reset only.
// RULE18 - Any write to a count byte clears the prescaler.
// RULE19 - Timer mode counts the quarter-rate instruction clock; sync bit ignored.
// RULE20 - After enabling, counter mode needs a falling edge before counting.
// RULE21 - The on bit enables counting when set and stops it when clear.
// RULE22 - Prescale codes 0 to 3 divide the input by 1, 2, 4 or 8.
// RULE23 - Rollover from all ones sets the overflow flag, gated onto interrupt.
module timer_counter16
  import tmr16_pkg::*;
(
  // Clock and resets
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic              warm_rst_i,
  // APB slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [DATA_W-1:0] pwdata_i,
  output logic      [DATA_W-1:0] prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // Count inputs and system state
  input  wire logic              ext_count_pin_i,
  input  wire logic              osc_input_pin_i,
  input  wire logic              sleep_i,
  // Compare unit
  input  wire logic [3:0]        compare_mode_field_i,
  input  wire logic [15:0]       compare_value_pair_i,
  // Outputs to the rest of the device
  output logic                   crystal_osc_on_o,
  output logic                   overflow_irq_o,
  output logic      [15:0]       timebase_o,
  output logic                   timebase_valid_o
);

  apb_req_t          req;
  ctrl_t             ctrl_r;
  ctrl_t             ctrl_nxt;
  logic              flag_r;
  logic              flag_nxt;
  logic              en_r;
  logic              en_nxt;
  logic              irq_r;
  logic              irq_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic              ready_r;
  logic              ready_nxt;
  logic              err_r;
  logic              err_nxt;
  logic [15:0]       count_r;
  logic [15:0]       count_nxt;
  logic [2:0]        pre_r;
  logic [2:0]        pre_nxt;
  logic [1:0]        div_r;
  logic [1:0]        div_nxt;
  logic              prev_r;
  logic              prev_nxt;
  logic              armed_r;
  logic              armed_nxt;
  logic              sync_r;
  logic              sync_nxt;
  logic              osc_r;
  logic              valid_r;

  logic              setup;
  logic              access;
  logic [9:0]        idx;
  logic              hit;
  logic              wr_lo;
  logic              wr_hi;
  logic              wr_cnt;
  logic              wr_flags;
  logic              wr_en;
  logic              wr_ctrl;
  logic              src;
  logic              rise;
  logic              fall;
  logic              instr_tick;
  logic              in_tick;
  logic [2:0]        pre_mask;
  logic              pre_out;
  logic              async_mode;
  logic              inc;
  logic              trig;
  logic              ovf_set;

  assign req = '{sel: psel_i, enable: penable_i, write: pwrite_i,
                 addr: paddr_i, wdata: pwdata_i};

  // Bus phases and address decode
  assign setup  = req.sel & ~req.enable;
  assign access = req.sel & req.enable & ready_r;
  assign idx    = req.addr[11:2];
  assign hit    = (req.addr[1:0] == 2'h0) &&
                  (idx == IDX_FLAGS || idx == IDX_CNT_LO ||
                   idx == IDX_CNT_HI || idx == IDX_CTRL ||
                   idx == IDX_ENABLES);

  // Write strobes act only at the access edge of a mapped address
  always_comb begin
    wr_lo    = access & req.write & ~err_r & (idx == IDX_CNT_LO);
    wr_hi    = access & req.write & ~err_r & (idx == IDX_CNT_HI);
    wr_flags = access & req.write & ~err_r & (idx == IDX_FLAGS);
    wr_en    = access & req.write & ~err_r & (idx == IDX_ENABLES);
    wr_ctrl  = access & req.write & ~err_r & (idx == IDX_CTRL);
    wr_cnt   = wr_lo | wr_hi;
  end

  // Read data is captured from the registers in the setup cycle
  always_comb begin
    rdata_nxt = rdata_r;
    ready_nxt = setup;
    err_nxt   = setup & ~hit;
    if (setup) begin
      rdata_nxt = '0;
      // Refused addresses, misaligned ones too, read as zero
      unique case (hit ? idx : 10'h000)
        IDX_FLAGS:   rdata_nxt[OVF_BIT] = flag_r;
        IDX_ENABLES: rdata_nxt[OVF_BIT] = en_r;
        IDX_CNT_LO:  rdata_nxt[7:0] = count_r[7:0];   // RULE7
        IDX_CNT_HI:  rdata_nxt[7:0] = count_r[15:8];  // RULE7
        IDX_CTRL:    rdata_nxt[7:0] = {2'h0, ctrl_r[5:0]};
        default:     rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || warm_rst_i) begin
      rdata_r <= '0;
      ready_r <= 1'b0;
      err_r   <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      ready_r <= ready_nxt;
      err_r   <= err_nxt;
    end
  end

  // Control, flag and enable registers
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl) begin
      ctrl_nxt = ctrl_t'({2'h0, req.wdata[5:0]});
    end
    en_nxt = wr_en ? req.wdata[OVF_BIT] : en_r;
    flag_nxt = wr_flags ? req.wdata[OVF_BIT] : flag_r;
    flag_nxt = flag_nxt | ovf_set;  // RULE23
    irq_nxt  = flag_r & en_r;       // RULE5
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctrl_r <= ctrl_t'(CTRL_RST);  // RULE17
    end else begin
      ctrl_r <= ctrl_nxt;           // RULE17
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || warm_rst_i) begin
      flag_r  <= FLAG_RST;
      en_r    <= EN_RST;
      irq_r   <= 1'b0;
      osc_r   <= 1'b0;
      valid_r <= 1'b0;
    end else begin
      flag_r  <= flag_nxt;
      en_r    <= en_nxt;
      irq_r   <= irq_nxt;
      osc_r   <= ctrl_r.crystal_osc_enable;  // RULE9
      valid_r <= ~async_mode;                // RULE6
    end
  end

  // Input selection, edge detection and prescaler
  assign src = ctrl_r.crystal_osc_enable ? osc_input_pin_i
                                          : ext_count_pin_i;  // RULE1
  assign rise       = src & ~prev_r;
  assign fall       = ~src & prev_r;
  assign async_mode = ctrl_r.count_source_select & ctrl_r.sync_bypass;
  // Instruction clock stops in sleep
  assign instr_tick = (div_r == INSTR_LAST) & ~sleep_i;  // RULE19

  always_comb begin
    unique case (ctrl_r.prescale_select)  // RULE22
      2'h0: pre_mask = 3'h0;
      2'h1: pre_mask = 3'h1;
      2'h2: pre_mask = 3'h3;
      2'h3: pre_mask = 3'h7;
    endcase
  end

  always_comb begin
    div_nxt   = div_r + 2'h1;
    prev_nxt  = src;
    armed_nxt = armed_r;
    if (!ctrl_r.counter_on) begin
      armed_nxt = 1'b0;
    end else if (fall) begin
      armed_nxt = 1'b1;  // RULE20
    end
    in_tick = ctrl_r.counter_on &                    // RULE21
              (ctrl_r.count_source_select ? (rise & armed_r)
                                          : instr_tick);
    pre_out = in_tick & ((pre_r & pre_mask) == pre_mask);  // RULE3
    pre_nxt = pre_r;
    if (wr_cnt) begin
      pre_nxt = PRE_RST;  // RULE18
    end else if (in_tick) begin
      pre_nxt = pre_r + 3'h1;  // RULE4
    end
    // Sync stage is shut off in sleep
    sync_nxt = pre_out & ~sleep_i;  // RULE2 RULE4
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || warm_rst_i) begin
      div_r   <= DIV_RST;
      prev_r  <= 1'b0;
      armed_r <= 1'b0;
      pre_r   <= PRE_RST;
      sync_r  <= 1'b0;
    end else begin
      div_r   <= div_nxt;
      prev_r  <= prev_nxt;
      armed_r <= armed_nxt;
      pre_r   <= pre_nxt;
      sync_r  <= sync_nxt;
    end
  end

  // Count register; never reset
  always_comb begin
    if (!ctrl_r.count_source_select) begin
      inc = pre_out;           // RULE19
    end else if (ctrl_r.sync_bypass) begin
      inc = pre_out;           // RULE5
    end else begin
      inc = sync_r & ctrl_r.counter_on;  // RULE2
    end
    trig = (compare_mode_field_i == TRIG_MODE) &&      // RULE11
           (count_r == compare_value_pair_i) &&        // RULE15
           !async_mode;                                // RULE13
    ovf_set = inc & ~wr_cnt & ~trig & (count_r == CNT_MAX);  // RULE12
    count_nxt = count_r;
    if (wr_lo) begin
      count_nxt[7:0] = req.wdata[7:0];   // RULE14
    end else if (wr_hi) begin
      count_nxt[15:8] = req.wdata[7:0];  // RULE14
    end else if (trig) begin
      count_nxt = 16'h0000;              // RULE11
    end else if (inc) begin
      count_nxt = count_r + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    count_r <= count_nxt;  // RULE16
  end

  assign prdata_o         = rdata_r;
  assign pready_o         = ready_r;
  assign pslverr_o        = err_r;
  assign crystal_osc_on_o = osc_r;
  assign overflow_irq_o   = irq_r;
  assign timebase_o       = count_r;
  assign timebase_valid_o = valid_r;

  // Count bytes that hold a defined value; the count itself has no reset
  logic [1:0]        known_r;
  logic [1:0]        known_nxt;

  always_comb begin
    known_nxt = known_r | {wr_hi | trig, wr_lo | trig};
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      known_r <= 2'h0;
    end else begin
      known_r <= known_nxt;
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i || warm_rst_i);

  a_write_beats_trig: assert property (  // RULE14
    wr_lo && trig |=> count_r[7:0] == $past(req.wdata[7:0]))
    else $error("count write lost to trigger clear");

  a_trig_clears_count: assert property (  // RULE11
    trig && !wr_cnt |=> count_r == 16'h0000)
    else $error("trigger did not clear count");

  a_trig_no_flag: assert property (  // RULE12
    trig && !flag_r && !wr_flags |=> !flag_r)
    else $error("trigger clear set overflow flag");

  a_rollover_flag: assert property (  // RULE23
    inc && !trig && !wr_cnt && count_r == CNT_MAX
    |=> flag_r && count_r == 16'h0000 ##1 irq_r == en_r)
    else $error("rollover did not raise flag");

  a_prescale_clear: assert property (  // RULE18
    wr_cnt |=> pre_r == PRE_RST)
    else $error("prescaler not cleared by count write");

  a_sleep_sync_hold: assert property (  // RULE4
    sleep_i && known_r == 2'h3 && ctrl_r.count_source_select
    && !ctrl_r.sync_bypass && !wr_cnt && !trig
    ##1 sleep_i && !wr_cnt && !trig
    |=> $stable(count_r))
    else $error("sync counter advanced in sleep");

  a_async_sleep_runs: assert property (  // RULE5
    sleep_i && async_mode && pre_out && !wr_cnt
    && count_r != CNT_MAX |=> count_r == $past(count_r) + 16'h0001)
    else $error("async counter stalled in sleep");

  a_off_no_count: assert property (  // RULE21
    !ctrl_r.counter_on && known_r == 2'h3
    ##1 !ctrl_r.counter_on && !wr_cnt && !trig
    |=> $stable(count_r))
    else $error("stopped counter advanced");

  a_needs_falling: assert property (  // RULE20
    $rose(ctrl_r.counter_on) ##0 !fall ##1 !fall |-> !armed_r)
    else $error("counting before falling edge");

  a_no_tick_unarmed: assert property (  // RULE20
    ctrl_r.count_source_select && !armed_r |-> !in_tick)
    else $error("count input ticked before falling edge");

  a_async_not_base: assert property (  // RULE6
    async_mode ##1 async_mode |-> !timebase_valid_o)
    else $error("async count offered as time base");

  a_warm_keeps_ctrl: assert property (  // RULE17
    disable iff (rst_i)
    warm_rst_i && !rst_i |=> ctrl_r == $past(ctrl_r))
    else $error("control changed by other reset");

  a_bus_answer: assert property (
    setup |=> pready_o && pslverr_o == !$past(hit))
    else $error("bus answer missing");

  c_trig_clear: cover property (trig && inc);
  c_rollover:   cover property (ovf_set ##1 irq_nxt);
  c_sleep_async: cover property (sleep_i && async_mode && inc);
  c_write_trig: cover property (wr_cnt && trig);

endmodule

// File: design/tmr16_pkg.sv
// Package with register map, control layout and constants of the timer
package tmr16_pkg;

  // Bus geometry
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_FLAGS   = 10'h00c;
  localparam logic [9:0] IDX_CNT_LO  = 10'h00e;
  localparam logic [9:0] IDX_CNT_HI  = 10'h00f;
  localparam logic [9:0] IDX_CTRL    = 10'h010;
  localparam logic [9:0] IDX_ENABLES = 10'h08c;

  // Bit position of the overflow flag and its enable
  localparam int unsigned OVF_BIT = 0;

  // Reset values
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic       FLAG_RST  = 1'b0;
  localparam logic       EN_RST    = 1'b0;
  localparam logic [2:0] PRE_RST   = 3'h0;
  localparam logic [1:0] DIV_RST   = 2'h0;

  // Instruction clock is a quarter of the reference clock
  localparam int unsigned INSTR_DIV  = 4;
  localparam logic [1:0]  INSTR_LAST = 2'(INSTR_DIV - 1);

  // Compare mode code that requests the counter clear
  localparam logic [3:0] TRIG_MODE = 4'hb;

  // Value of the count before it rolls over
  localparam logic [15:0] CNT_MAX = 16'hffff;

  // Control register layout
  typedef struct packed {
    logic [1:0] unused;
    logic [1:0] prescale_select;
    logic       crystal_osc_enable;
    logic       sync_bypass;
    logic       count_source_select;
    logic       counter_on;
  } ctrl_t;

  // Signals of one APB request
  typedef struct packed {
    logic              sel;
    logic              enable;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } apb_req_t;

endpackage

// File: tb/ext_clk_src.sv
// Model of the external count source and the crystal oscillator
`timescale 1ns/100ps
module ext_clk_src (
  // Clock and request
  input  wire logic       ref_clk_i,
  input  wire logic       go_i,
  input  wire logic       osc_sel_i,
  input  wire logic [7:0] pulses_i,
  input  wire logic [3:0] half_i,
  // Pins
  output logic            ext_count_pin_o,
  output logic            osc_input_pin_o,
  output logic            busy_o
);
  // Both pins rest low between bursts
  initial begin
    ext_count_pin_o = 1'b0;
    osc_input_pin_o = 1'b0;
    busy_o = 1'b0;
    forever begin
      @(posedge ref_clk_i);
      if (go_i) begin
        busy_o <= 1'b1;
        repeat (pulses_i) begin
          repeat (half_i) @(posedge ref_clk_i);
          osc_input_pin_o <= osc_sel_i;
          ext_count_pin_o <= !osc_sel_i;
          repeat (half_i) @(posedge ref_clk_i);
          osc_input_pin_o <= 1'b0;
          ext_count_pin_o <= 1'b0;
        end
        busy_o <= 1'b0;
      end
    end
  end
endmodule

// File: tb/sixteen_bit_timer_counter_test.sv
// Self-checking bench of the sixteen-bit timer/counter
`timescale 1ns/100ps
module sixteen_bit_timer_counter_test;
  import tmr16_pkg::*;
  logic              clk, rst, warm, psel, pen, pwr, slp, go, osel;
  logic              rdy, err, osc_on, irq, tbv, ext, osc, busy;
  logic [ADDR_W-1:0] padr;
  logic [DATA_W-1:0] pwd, prd;
  logic [3:0]        cmode;
  logic [15:0]       cval, tbase, cnt, mx;
  logic [7:0]        npul, rv;
  logic              rerr;
  int                miscompares = 0;
  int                checks = 0;

  timer_counter16 i_dut (.ref_clk_i(clk), .rst_i(rst), .warm_rst_i(warm),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(padr),
    .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err),
    .ext_count_pin_i(ext), .osc_input_pin_i(osc), .sleep_i(slp),
    .compare_mode_field_i(cmode), .compare_value_pair_i(cval),
    .crystal_osc_on_o(osc_on), .overflow_irq_o(irq), .timebase_o(tbase),
    .timebase_valid_o(tbv));
  ext_clk_src i_src (.ref_clk_i(clk), .go_i(go), .osc_sel_i(osel),
    .pulses_i(npul), .half_i(4'h3), .ext_count_pin_o(ext),
    .osc_input_pin_o(osc), .busy_o(busy));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic hang();
    miscompares++;
    summarize();
  endtask

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    padr <= {idx, 2'b00};
    pwd <= 32'(d);
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (n == 20) hang();
    rv = prd[7:0];
    rerr = err;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task automatic cnt_set(input logic [15:0] v);
    apb(1'b1, IDX_CNT_LO, v[7:0]);
    apb(1'b1, IDX_CNT_HI, v[15:8]);
  endtask

  task automatic cnt_get();
    apb(1'b0, IDX_CNT_LO, 8'h00);
    cnt[7:0] = rv;
    apb(1'b0, IDX_CNT_HI, 8'h00);
    cnt[15:8] = rv;
  endtask

  task automatic pulses(input logic [7:0] n, input logic os);
    int k;
    osel <= os;
    npul <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (busy !== 1'b0 && k < 400);
    if (k == 400) hang();
  endtask

  task automatic t_regs();
    apb(1'b0, IDX_CTRL, 8'h00);
    chk("ctrl reset", 16'(rv), 16'h0000);
    apb(1'b0, 10'h3ff, 8'h00);
    chk("unmapped err", 16'(rerr), 16'h0001);
    apb(1'b1, IDX_CTRL, 8'hfe);
    apb(1'b0, IDX_CTRL, 8'h00);
    chk("ctrl rw", 16'(rv), 16'h003e);
    chk("osc on", 16'(osc_on), 16'h0001);
    apb(1'b1, IDX_CTRL, 8'h00);
    cnt_set(16'h1234);
    apb(1'b1, IDX_CTRL, 8'h3e);
    warm <= 1'b1;
    repeat (2) @(posedge clk);
    warm <= 1'b0;
    @(posedge clk);
    apb(1'b0, IDX_CTRL, 8'h00);
    chk("ctrl warm", 16'(rv), 16'h003e);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, IDX_CTRL, 8'h00);
    chk("ctrl por", 16'(rv), 16'h0000);
    cnt_get();
    chk("cnt kept", cnt, 16'h1234);
  endtask

  // Counter mode; first pulse only arms the edge detector
  task automatic t_count(input logic [1:0] ps, input logic os);
    cnt_set(16'h0000);
    if (os) begin
      apb(1'b1, IDX_CTRL, {2'b00, ps, os, 3'b010});
      repeat (8) @(posedge clk);
    end
    apb(1'b1, IDX_CTRL, {2'b00, ps, os, 3'b011});
    pulses(8'd17, os);
    apb(1'b1, IDX_CTRL, 8'h00);
    cnt_get();
    chk("prescaled", cnt, 16'h0010 >> ps);
  endtask

  task automatic t_sleep(input logic async);
    cnt_set(16'h0000);
    slp <= 1'b1;
    apb(1'b1, IDX_CTRL, {5'h00, async, 2'b11});
    @(posedge clk);
    chk("tb valid", 16'(tbv), 16'(!async));
    pulses(8'd9, 1'b0);
    apb(1'b1, IDX_CTRL, 8'h00);
    slp <= 1'b0;
    cnt_get();
    chk("sleep cnt", cnt, async ? 16'h0008 : 16'h0000);
  endtask

  task automatic t_timer();
    cnt_set(16'h0000);
    apb(1'b1, IDX_CTRL, 8'h05);
    repeat (40) @(posedge clk);
    chk("timer valid", 16'(tbv), 16'h0001);
    apb(1'b1, IDX_CTRL, 8'h00);
    cnt_get();
    chk("timer rate", 16'(cnt > 9 && cnt < 14), 16'h0001);
  endtask

  task automatic t_ovf();
    int k;
    apb(1'b1, IDX_ENABLES, 8'h01);
    cnt_set(16'hfffd);
    apb(1'b1, IDX_CTRL, 8'h01);
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (irq !== 1'b1 && k < 60);
    chk("irq", 16'(irq), 16'h0001);
    apb(1'b1, IDX_CTRL, 8'h00);
    apb(1'b0, IDX_FLAGS, 8'h00);
    chk("flag set", 16'(rv[OVF_BIT]), 16'h0001);
    apb(1'b1, IDX_FLAGS, 8'h00);
    apb(1'b0, IDX_FLAGS, 8'h00);
    chk("flag clr", 16'(rv[OVF_BIT]), 16'h0000);
  endtask

  task automatic t_trig();
    cmode <= TRIG_MODE;
    cval <= 16'h0005;
    cnt_set(16'h0000);
    apb(1'b1, IDX_CTRL, 8'h01);
    mx = 16'h0000;
    repeat (100) begin
      @(posedge clk);
      if (tbase > mx) mx = tbase;
    end
    apb(1'b1, IDX_CTRL, 8'h00);
    cmode <= 4'h0;
    chk("period", mx, 16'h0005);
    apb(1'b0, IDX_FLAGS, 8'h00);
    chk("no flag", 16'(rv[OVF_BIT]), 16'h0000);
  endtask

  initial begin
    {rst, warm, psel, pen, pwr, slp, go, osel} = 8'h80;
    padr = '0;
    pwd = '0;
    cmode = 4'h0;
    cval = 16'h0000;
    npul = 8'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    for (int c = 0; c < 4; c++) t_count(2'(c), c[0]);
    t_sleep(1'b0);
    t_sleep(1'b1);
    t_timer();
    t_ovf();
    t_trig();
    summarize();
  end
endmodule
